// ---- rtl/ssr_defs.svh ----
// Bit positions, command codes and reset values of the status summary block
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH
`define SSR_BIT_ALARM 0
`define SSR_BIT_TRIG 1
`define SSR_BIT_READY 2
`define SSR_BIT_SCAN 3
`define SSR_BIT_OUTQ 4
`define SSR_BIT_ESUM 5
`define SSR_BIT_RQS 6
`define SSR_BIT_OVR 7
`define SSR_EV_ACQ_DONE 0
`define SSR_EV_STOP 1
`define SSR_EV_QUERY_ERR 2
`define SSR_EV_CONFLICT_ERR 3
`define SSR_EV_EXEC_ERR 4
`define SSR_EV_CMD_ERR 5
`define SSR_EV_LIMIT 6
`define SSR_EV_POWER_ON 7
`define SSR_ERR_CLR_MASK 8'h38
`define SSR_MASK_RESET 8'h00
`define SSR_CMD_NOP 4'h0
`define SSR_CMD_EVENT_MASK_WR 4'h1
`define SSR_CMD_EVENT_MASK_RD 4'h2
`define SSR_CMD_REQ_MASK_WR 4'h3
`define SSR_CMD_REQ_MASK_RD 4'h4
`define SSR_CMD_STATUS_BYTE_RD 4'h5
`define SSR_CMD_EVENT_RD 4'h6
`define SSR_CMD_ERROR_QUERY 4'h7
`define SSR_CMD_FULL_RESET 4'h8
`define SSR_CMD_SERIAL_POLL 4'h9
`endif

// ---- rtl/ssr_pkg.sv ----
// Types shared by the status summary block
package ssr_pkg;
	typedef struct packed {
		logic [3:0] code;
		logic [7:0] data;
		logic valid;
	} ssr_cmd_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ssr_resp_t;
	typedef struct packed {
		logic alarm;
		logic trig_det;
		logic acq_done;
		logic trig_reconf;
		logic busy;
		logic scan_avail;
		logic outq_nonempty;
		logic overrun;
		logic buf_empty;
		logic buf_clear;
	} ssr_acq_t;
endpackage

// ---- rtl/ssr_sync.sv ----
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`include "ssr_defs.svh"
module ssr_sync #(
	parameter int W = 2
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // ssr_sync

// ---- rtl/ssr_latch.sv ----
// Event latch register with per-bit set and clear
`timescale 1ns/1ps
`include "ssr_defs.svh"
module ssr_latch (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] set_in,
	input wire logic [7:0] clr_in,
	output logic [7:0] q
);
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			// Set wins over a clear in the same cycle
			always_ff @(posedge mclk) begin
				if (reset) begin
					q[i] <= 1'b0;
				end else if (set_in[i]) begin
					q[i] <= 1'b1;
				end else if (clr_in[i]) begin
					q[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule // ssr_latch

// ---- rtl/ssr_top.sv ----
// Status summary and service request logic of the acquisition instrument
`timescale 1ns/1ps
`include "ssr_defs.svh"
module ssr_top (
	input wire logic mclk,
	input wire logic reset,
	input ssr_pkg::ssr_cmd_t cmd,
	input ssr_pkg::ssr_acq_t acq,
	input wire logic [7:0] event_set,
	input wire logic alarm_pin,
	input wire logic trig_pin,
	output ssr_pkg::ssr_resp_t resp,
	output logic [7:0] status_byte,
	output logic service_request_n
);
	logic [1:0] pin_sync;
	logic [7:0] event_latch_register;
	logic [7:0] latch_set;
	logic [7:0] latch_clr;
	logic [7:0] event_enable_mask_reg;
	logic [7:0] request_enable_mask_reg;
	logic [7:0] stb_reg;
	logic [7:0] stb_next;
	logic event_summary_flag;
	logic master_summary_flag;
	logic rqs_reg;
	logic ready_next;
	logic cmd_hit;
	logic clr_all;
	logic alarm_now;
	logic trig_now;

	ssr_sync #(.W(2)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.d({trig_pin, alarm_pin}),
		.q(pin_sync)
	);
	assign alarm_now = pin_sync[0] | acq.alarm;
	assign trig_now = pin_sync[1] | acq.trig_det;
	assign cmd_hit = cmd.valid;

	// error sources latched at bits 5,4,3,2 by caller layout
	assign latch_set = event_set;
	// event read clears latch; error query clears error bits 5,4,3 but not the query error bit 2
	always_comb begin
		latch_clr = 8'h00;
		if (cmd_hit && (cmd.code == `SSR_CMD_EVENT_RD || cmd.code == `SSR_CMD_FULL_RESET)) begin
			latch_clr = 8'hFF;
		end else if (cmd_hit && cmd.code == `SSR_CMD_ERROR_QUERY) begin
			latch_clr = `SSR_ERR_CLR_MASK;
		end
	end

	// latch sees no mask write path
	ssr_latch u_latch (
		.mclk(mclk),
		.reset(reset),
		.set_in(latch_set),
		.clr_in(latch_clr),
		.q(event_latch_register)
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			event_enable_mask_reg <= `SSR_MASK_RESET;
		end else if (cmd_hit && cmd.code == `SSR_CMD_EVENT_MASK_WR) begin
			event_enable_mask_reg <= cmd.data;
		end else if (cmd_hit && cmd.code == `SSR_CMD_FULL_RESET) begin
			event_enable_mask_reg <= `SSR_MASK_RESET;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			request_enable_mask_reg <= `SSR_MASK_RESET;
		end else if (cmd_hit && cmd.code == `SSR_CMD_REQ_MASK_WR) begin
			request_enable_mask_reg <= cmd.data;
		end else if (cmd_hit && cmd.code == `SSR_CMD_FULL_RESET) begin
			request_enable_mask_reg <= `SSR_MASK_RESET;
		end
	end

	assign event_summary_flag = |(event_latch_register & event_enable_mask_reg);

	// ready low while a command line is in progress
	assign ready_next = ~acq.busy & ~cmd_hit;
	assign clr_all = cmd_hit &&
		(cmd.code == `SSR_CMD_STATUS_BYTE_RD || cmd.code == `SSR_CMD_FULL_RESET);

	// Level bits recover next cycle after a clear; event bits are set again whenever their source is high
	always_comb begin
		stb_next = stb_reg;
		stb_next[`SSR_BIT_ALARM] = alarm_now;
		if (acq.acq_done || acq.trig_reconf) begin
			stb_next[`SSR_BIT_TRIG] = 1'b0;
		end
		if (clr_all) begin
			stb_next[`SSR_BIT_TRIG] = 1'b0;
		end
		if (trig_now) begin
			stb_next[`SSR_BIT_TRIG] = 1'b1;
		end
		stb_next[`SSR_BIT_READY] = ready_next;
		stb_next[`SSR_BIT_SCAN] = acq.scan_avail;
		stb_next[`SSR_BIT_OUTQ] = acq.outq_nonempty;
		stb_next[`SSR_BIT_ESUM] = event_summary_flag;
		// overrun sticky until buffer empty or cleared
		if (acq.buf_empty || acq.buf_clear || clr_all) begin
			stb_next[`SSR_BIT_OVR] = 1'b0;
		end
		if (acq.overrun) begin
			stb_next[`SSR_BIT_OVR] = 1'b1;
		end
		// read or full reset clears scan, output queue and summary copies this cycle; alarm keeps following alarm_now
		if (clr_all) begin
			stb_next[`SSR_BIT_ALARM] = alarm_now;
			stb_next[`SSR_BIT_SCAN] = 1'b0;
			stb_next[`SSR_BIT_OUTQ] = 1'b0;
			stb_next[`SSR_BIT_ESUM] = 1'b0;
		end
		stb_next[`SSR_BIT_RQS] = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			stb_reg <= 8'h00;
		end else begin
			stb_reg <= stb_next;
		end
	end

	// masked status byte forms master summary
	assign master_summary_flag = |(stb_reg & request_enable_mask_reg & 8'hBF);

	// request on rising summary, cleared by serial poll
	logic msf_prev_reg;
	always_ff @(posedge mclk) begin
		if (reset) begin
			msf_prev_reg <= 1'b0;
		end else begin
			msf_prev_reg <= master_summary_flag;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			rqs_reg <= 1'b0;
		end else if (master_summary_flag && !msf_prev_reg) begin
			rqs_reg <= 1'b1;
		end else if (cmd_hit && (cmd.code == `SSR_CMD_SERIAL_POLL ||
			cmd.code == `SSR_CMD_STATUS_BYTE_RD || cmd.code == `SSR_CMD_FULL_RESET)) begin
			rqs_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			status_byte <= 8'h00;
		end else begin
			status_byte <= {stb_next[7], rqs_reg, stb_next[5:0]};
		end
	end

	// active-low request line follows request bit
	always_ff @(posedge mclk) begin
		if (reset) begin
			service_request_n <= 1'b1;
		end else begin
			service_request_n <= ~rqs_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			resp <= '0;
		end else begin
			resp.valid <= 1'b0;
			resp.data <= 8'h00;
			if (cmd_hit) begin
				unique case (cmd.code)
					`SSR_CMD_EVENT_MASK_RD: begin
						resp.valid <= 1'b1;
						resp.data <= event_enable_mask_reg;
					end
					`SSR_CMD_REQ_MASK_RD: begin
						resp.valid <= 1'b1;
						resp.data <= request_enable_mask_reg;
					end
					`SSR_CMD_EVENT_RD: begin
						resp.valid <= 1'b1;
						resp.data <= event_latch_register;
					end
					`SSR_CMD_STATUS_BYTE_RD, `SSR_CMD_SERIAL_POLL: begin
						resp.valid <= 1'b1;
						resp.data <= {stb_reg[7], rqs_reg, stb_reg[5:0]};
					end
					default: begin
						resp.valid <= 1'b0;
					end
				endcase
			end
		end
	end

	// Checks
	sequence s_ev_read;
		cmd.valid && cmd.code == `SSR_CMD_EVENT_RD && event_set == 8'h00;
	endsequence
	chk_esum_mask: assert property (@(posedge mclk) disable iff (reset)
		!clr_all |=> status_byte[`SSR_BIT_ESUM] ==
		$past(|(event_latch_register & event_enable_mask_reg)))
		else $error("event summary mismatch");
	chk_latch_stable: assert property (@(posedge mclk) disable iff (reset)
		(cmd.valid && cmd.code == `SSR_CMD_EVENT_MASK_WR && event_set == 8'h00)
		|=> event_latch_register == $past(event_latch_register))
		else $error("mask write changed latch");
	chk_emask_wr: assert property (@(posedge mclk) disable iff (reset)
		(cmd.valid && cmd.code == `SSR_CMD_EVENT_MASK_WR) |=> event_enable_mask_reg == $past(cmd.data))
		else $error("event mask not written");
	chk_stb_clear: assert property (@(posedge mclk) disable iff (reset)
		clr_all |=> stb_reg[`SSR_BIT_ESUM] == 1'b0 && stb_reg[`SSR_BIT_SCAN] == 1'b0)
		else $error("status byte not cleared");
	chk_err_clear: assert property (@(posedge mclk) disable iff (reset)
		(cmd.valid && cmd.code == `SSR_CMD_ERROR_QUERY && event_set == 8'h00)
		|=> (event_latch_register & `SSR_ERR_CLR_MASK) == 8'h00)
		else $error("error bits not cleared");
	chk_alarm_follow: assert property (@(posedge mclk) disable iff (reset)
		##1 stb_reg[`SSR_BIT_ALARM] == $past(alarm_now))
		else $error("alarm bit not following");
	chk_ev_read: assert property (@(posedge mclk) disable iff (reset)
		s_ev_read |=> event_latch_register == 8'h00 && resp.valid)
		else $error("event read failed");
	chk_rqs_poll: assert property (@(posedge mclk) disable iff (reset)
		(cmd.valid && cmd.code == `SSR_CMD_SERIAL_POLL && !(master_summary_flag && !msf_prev_reg))
		|=> !rqs_reg)
		else $error("poll did not clear request");
	chk_srq_pin: assert property (@(posedge mclk) disable iff (reset)
		rqs_reg |=> !service_request_n)
		else $error("request line not asserted");
	sequence s_msf_rise;
		master_summary_flag && !msf_prev_reg;
	endsequence
	// A trigger in the same cycle keeps the bit, so only a clean end is checked
	sequence s_trig_end;
		(acq.acq_done || acq.trig_reconf) && !trig_now;
	endsequence
	chk_trig_set: assert property (@(posedge mclk) disable iff (reset)
		trig_now |=> status_byte[`SSR_BIT_TRIG])
		else $error("trigger bit not set");
	chk_trig_clear: assert property (@(posedge mclk) disable iff (reset)
		s_trig_end |=> !status_byte[`SSR_BIT_TRIG])
		else $error("trigger bit not cleared");
	chk_ready_line: assert property (@(posedge mclk) disable iff (reset)
		!reset |=> status_byte[`SSR_BIT_READY] == !$past(acq.busy || cmd.valid))
		else $error("ready bit wrong");
	chk_scan_follow: assert property (@(posedge mclk) disable iff (reset)
		!clr_all |=> status_byte[`SSR_BIT_SCAN] == $past(acq.scan_avail))
		else $error("scan bit not following");
	chk_outq_follow: assert property (@(posedge mclk) disable iff (reset)
		!clr_all |=> status_byte[`SSR_BIT_OUTQ] == $past(acq.outq_nonempty))
		else $error("output pending bit not following");
	chk_ovr_set: assert property (@(posedge mclk) disable iff (reset)
		acq.overrun |=> status_byte[`SSR_BIT_OVR])
		else $error("overrun bit not set");
	chk_ovr_clear: assert property (@(posedge mclk) disable iff (reset)
		(acq.buf_empty || acq.buf_clear) && !acq.overrun |=> !status_byte[`SSR_BIT_OVR])
		else $error("overrun bit not cleared");
	chk_rqs_raise: assert property (@(posedge mclk) disable iff (reset)
		s_msf_rise |=> rqs_reg)
		else $error("request bit not raised");
	chk_rmask_wr: assert property (@(posedge mclk) disable iff (reset)
		(cmd.valid && cmd.code == `SSR_CMD_REQ_MASK_WR) |=> request_enable_mask_reg == $past(cmd.data))
		else $error("request mask not written");
endmodule // ssr_top

// ---- test/ssr_host.sv ----
// Host controller model that issues commands and collects the answers
`timescale 1ns/1ps
`include "ssr_defs.svh"
module ssr_host (
	input wire logic mclk,
	input ssr_pkg::ssr_resp_t resp,
	input wire logic [7:0] status_byte,
	output ssr_pkg::ssr_cmd_t cmd
);
	logic [7:0] rd_data;
	logic got;
	int n_stall = 0;
	initial cmd = '0;
	task automatic issue(input logic [3:0] code, input logic [7:0] data);
		for (int i = 0; i < 16 && status_byte[`SSR_BIT_READY] !== 1'b1; i++) @(posedge mclk);
		// A ready bit that never came counts against the run
		if (status_byte[`SSR_BIT_READY] !== 1'b1) begin
			n_stall++;
		end
		@(posedge mclk);
		cmd <= {code, data, 1'b1};
		@(posedge mclk);
		cmd <= '0;
		#1;
		got = resp.valid;
		rd_data = resp.data;
	endtask
endmodule // ssr_host

// ---- test/testbench.sv ----
// Self-checking bench of the status summary block
`timescale 1ns/1ps
`include "ssr_defs.svh"
module testbench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	ssr_pkg::ssr_cmd_t cmd;
	ssr_pkg::ssr_acq_t acq = '0;
	ssr_pkg::ssr_resp_t resp;
	logic [7:0] event_set = 8'h00;
	logic alarm_pin = 1'b0;
	logic trig_pin = 1'b0;
	logic [7:0] status_byte;
	logic service_request_n;
	int n_mismatch = 0;
	int compares = 0;
	always #5 mclk = ~mclk;
	ssr_top i_ssr_top (.mclk(mclk), .reset(reset), .cmd(cmd), .acq(acq), .event_set(event_set),
		.alarm_pin(alarm_pin), .trig_pin(trig_pin), .resp(resp), .status_byte(status_byte),
		.service_request_n(service_request_n));
	ssr_host i_ssr_host (.mclk(mclk), .resp(resp), .status_byte(status_byte), .cmd(cmd));
	task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_bit(input int idx, input logic v);
		for (int i = 0; i < 8 && status_byte[idx] !== v; i++) @(posedge mclk) #1;
		cmp({8'h00, status_byte[idx]}, {8'h00, v});
	endtask
	task automatic rd(input logic [3:0] c, input logic [7:0] exp);
		i_ssr_host.issue(c, 8'h00);
		cmp({i_ssr_host.got, i_ssr_host.rd_data}, {1'b1, exp});
	endtask
	task automatic pa(input int f);
		@(posedge mclk);
		acq[f] <= 1'b1;
		@(posedge mclk);
		acq[f] <= 1'b0;
	endtask
	task automatic lvl(input int f, input int b, input logic inv);
		@(posedge mclk);
		acq[f] <= 1'b1;
		wait_bit(b, ~inv);
		@(posedge mclk);
		acq[f] <= 1'b0;
		wait_bit(b, inv);
	endtask
	task automatic t_masks();
		i_ssr_host.issue(`SSR_CMD_EVENT_RD, 8'h00);
		rd(`SSR_CMD_EVENT_MASK_RD, 8'h00);
		i_ssr_host.issue(`SSR_CMD_EVENT_MASK_WR, 8'hA5);
		rd(`SSR_CMD_EVENT_MASK_RD, 8'hA5);
		i_ssr_host.issue(`SSR_CMD_REQ_MASK_WR, 8'h5A);
		rd(`SSR_CMD_REQ_MASK_RD, 8'h5A);
		i_ssr_host.issue(`SSR_CMD_EVENT_MASK_WR, 8'h00);
		i_ssr_host.issue(`SSR_CMD_REQ_MASK_WR, 8'h00);
	endtask
	task automatic t_event();
		@(posedge mclk);
		event_set <= 8'h20;
		@(posedge mclk);
		event_set <= 8'h00;
		wait_bit(`SSR_BIT_ESUM, 1'b0);
		i_ssr_host.issue(`SSR_CMD_EVENT_MASK_WR, 8'h20);
		wait_bit(`SSR_BIT_ESUM, 1'b1);
		i_ssr_host.issue(`SSR_CMD_EVENT_MASK_WR, 8'h00);
		wait_bit(`SSR_BIT_ESUM, 1'b0);
		rd(`SSR_CMD_EVENT_RD, 8'h20);
		rd(`SSR_CMD_EVENT_RD, 8'h00);
		@(posedge mclk);
		event_set <= 8'h39;
		@(posedge mclk);
		event_set <= 8'h00;
		i_ssr_host.issue(`SSR_CMD_ERROR_QUERY, 8'h00);
		rd(`SSR_CMD_EVENT_RD, 8'h01);
	endtask
	task automatic t_bits();
		lvl(9, `SSR_BIT_ALARM, 1'b0);
		lvl(4, `SSR_BIT_SCAN, 1'b0);
		lvl(3, `SSR_BIT_OUTQ, 1'b0);
		lvl(5, `SSR_BIT_READY, 1'b1);
		@(posedge mclk);
		alarm_pin <= 1'b1;
		wait_bit(`SSR_BIT_ALARM, 1'b1);
		@(posedge mclk);
		alarm_pin <= 1'b0;
		wait_bit(`SSR_BIT_ALARM, 1'b0);
		pa(8);
		wait_bit(`SSR_BIT_TRIG, 1'b1);
		pa(7);
		wait_bit(`SSR_BIT_TRIG, 1'b0);
		@(posedge mclk);
		trig_pin <= 1'b1;
		wait_bit(`SSR_BIT_TRIG, 1'b1);
		@(posedge mclk);
		trig_pin <= 1'b0;
		// Let the synchronised pin drop first, else the set beats the clear
		repeat (3) @(posedge mclk);
		pa(6);
		wait_bit(`SSR_BIT_TRIG, 1'b0);
		pa(2);
		wait_bit(`SSR_BIT_OVR, 1'b1);
		pa(0);
		wait_bit(`SSR_BIT_OVR, 1'b0);
		pa(2);
		pa(1);
		wait_bit(`SSR_BIT_OVR, 1'b0);
		pa(2);
		wait_bit(`SSR_BIT_OVR, 1'b1);
		// Host on the serial link reads the byte by command
		i_ssr_host.issue(`SSR_CMD_STATUS_BYTE_RD, 8'h00);
		cmp({8'h00, i_ssr_host.rd_data[7]}, 9'h001);
		wait_bit(`SSR_BIT_OVR, 1'b0);
	endtask
	task automatic t_srq();
		i_ssr_host.issue(`SSR_CMD_REQ_MASK_WR, 8'h08);
		@(posedge mclk);
		acq.scan_avail <= 1'b1;
		wait_bit(`SSR_BIT_RQS, 1'b1);
		@(posedge mclk) #1;
		cmp({8'h00, service_request_n}, 9'h000);
		i_ssr_host.issue(`SSR_CMD_REQ_MASK_WR, 8'h00);
		wait_bit(`SSR_BIT_SCAN, 1'b1);
		i_ssr_host.issue(`SSR_CMD_SERIAL_POLL, 8'h00);
		cmp({8'h00, i_ssr_host.rd_data[6]}, 9'h001);
		wait_bit(`SSR_BIT_RQS, 1'b0);
		@(posedge mclk) #1;
		cmp({8'h00, service_request_n}, 9'h001);
		@(posedge mclk);
		acq.scan_avail <= 1'b0;
	endtask
	task automatic t_full_reset();
		i_ssr_host.issue(`SSR_CMD_EVENT_MASK_WR, 8'h11);
		i_ssr_host.issue(`SSR_CMD_REQ_MASK_WR, 8'h11);
		pa(8);
		wait_bit(`SSR_BIT_TRIG, 1'b1);
		i_ssr_host.issue(`SSR_CMD_FULL_RESET, 8'h00);
		wait_bit(`SSR_BIT_TRIG, 1'b0);
		rd(`SSR_CMD_EVENT_MASK_RD, 8'h00);
		rd(`SSR_CMD_REQ_MASK_RD, 8'h00);
	endtask
	task automatic give_verdict();
		n_mismatch += i_ssr_host.n_stall;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard: a stuck run still reaches the report
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		t_masks();
		t_event();
		t_bits();
		t_srq();
		t_full_reset();
		give_verdict();
	end
endmodule // testbench
